// *** bench/effective_address_generator_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module effective_address_generator_tb_top
   import eagen_pkg::*;
;
   localparam logic [15:0] VB = 16'h0040;
   logic clk_i = 1'b0;
   logic arst_n = 1'b0;
   logic start = 1'b0, pd = 1'b0, bfr = 1'b0, bro = 1'b0;
   logic impl = 1'b0, trap = 1'b0;
   mode_type mode = M_REG_DIRECT;
   class_type cls = C_TRANSFER;
   size_type sz = SZ_BYTE;
   len_type ln = L_8;
   logic [31:0] ext = '0, ar = '0, pdata = '0;
   logic [23:0] pc = '0;
   logic [3:0] rf = '0;
   logic [7:0] breg = '0, lat = '0;
   logic [2:0] bimm = '0;
   logic busy, done, err, eav, opv, rdh, rdv, wbe, mreq, bnv, tvv, ack;
   logic [15:0] ea, maddr, tv;
   logic [31:0] opd, wbd, rdat;
   logic [2:0] rdi, wbi, bn;
   size_type rds;
   int n_mismatch = 0, tests_run = 0, cyc = 0;
   mode_type ml[5] = '{M_REG_INDIRECT, M_DISP, M_AUTO, M_ABS, M_PC_REL};
   mode_type bm[3] = '{M_REG_DIRECT, M_REG_INDIRECT, M_ABS};

   effective_address_generator #(.TRAP_VEC_BASE(VB)) i_dut (
      .clk_i(clk_i), .arst_n_i(arst_n), .start_i(start), .mode_i(mode),
      .class_i(cls), .predec_i(pd), .size_i(sz), .len_i(ln), .ext_i(ext),
      .reg_field_i(rf), .address_register_i(ar), .pc_i(pc),
      .bit_from_reg_i(bfr), .bit_reg_op_i(bro), .bit_reg_i(breg),
      .bit_imm_i(bimm), .implicit_i(impl), .trap_i(trap),
      .mem_ack_i(ack), .mem_rdata_i(rdat), .busy_o(busy), .done_o(done),
      .mode_err_o(err), .ea_o(ea), .ea_valid_o(eav), .operand_o(opd),
      .operand_valid_o(opv), .rd_index_o(rdi), .rd_size_o(rds),
      .rd_hi_half_o(rdh), .rd_valid_o(rdv), .wb_en_o(wbe), .wb_data_o(wbd),
      .wb_index_o(wbi), .mem_req_o(mreq), .mem_addr_o(maddr),
      .bitnum_o(bn), .bitnum_valid_o(bnv), .trap_vec_o(tv),
      .trap_valid_o(tvv));

   ptr_mem_model i_mem (
      .clk_i(clk_i), .arst_n_i(arst_n), .req_i(mreq), .data_i(pdata),
      .lat_i(lat), .ack_o(ack), .rdata_o(rdat));

   always #20 clk_i = ~clk_i;

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   // Run is a few hundred cycles; the ceiling only catches a hang
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         conclude();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   function automatic logic [31:0] st();
      return sz == SZ_BYTE ? 32'h1 : sz == SZ_WORD ? 32'h2 : 32'h4;
   endfunction : st

   function automatic logic [31:0] fit(input len_type l, input logic [31:0] v);
      return l == L_8 ? v & 32'hFF : l == L_16 ? v & 32'hFFFF :
             l == L_24 ? v & 32'hFF_FFFF : v;
   endfunction : fit

   function automatic logic [15:0] xea();
      logic [31:0] s;
      logic [31:0] s16;
      s16 = {{16{ext[15]}}, ext[15:0]};
      case (mode)
         M_DISP: s = ar + (ln == L_16 ? s16 : ext);
         M_AUTO: s = pd ? ar - st() : ar;
         M_ABS: s = ln == L_8 ? {24'hFF_FFFF, ext[7:0]} :
                ln == L_16 ? s16 : ext;
         M_PC_REL: s = pc + (ln == L_8 ? {{24{ext[7]}}, ext[7:0]} : s16);
         default: s = ar;
      endcase
      return s[15:0];
   endfunction : xea

   function automatic logic legal();
      case (cls)
         C_ARITH: return mode inside {M_REG_DIRECT, M_IMM};
         C_TRANSFER: return !(mode inside {M_PC_REL, M_MEM_IND});
         C_BIT: return mode inside {M_REG_DIRECT, M_REG_INDIRECT, M_ABS};
         C_BRANCH: return mode == M_PC_REL;
         C_JUMP: return mode inside {M_REG_INDIRECT, M_ABS, M_MEM_IND};
         default: return mode inside {M_IMM, M_REG_DIRECT};
      endcase
   endfunction : legal

   task automatic wait_done();
      int n;
      n = 0;
      while (done !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         #2 n++;
      end
      chk("done", done, 1);
   endtask : wait_done

   task automatic req();
      @(posedge clk_i);
      #2 start = 1'b1;
      @(posedge clk_i);
      #2 start = 1'b0;
      wait_done();
   endtask : req

   task automatic ptr(input logic [7:0] d, input bit poke);
      cls = C_JUMP;
      mode = M_MEM_IND;
      ln = L_8;
      ext = fit(L_8, $urandom);
      pdata = $urandom;
      lat = d;
      @(posedge clk_i);
      #2 start = 1'b1;
      @(posedge clk_i);
      #2 start = 1'b0;
      chk("mem_req", mreq, 1);
      chk("busy", busy, 1);
      chk("mem_addr", maddr, {8'h00, ext[7:0]});
      if (poke) begin
         @(posedge clk_i);
         #2 start = 1'b1;
         @(posedge clk_i);
         #2 start = 1'b0;
      end
      wait_done();
      chk("ea_ptr", ea, pdata[15:0]);
      chk("ea_valid_ptr", eav, 1);
      chk("busy_end", busy, 0);
      @(posedge clk_i);
      #2 chk("done_once", done, 0);
   endtask : ptr

   initial begin
      void'($urandom(32'h0BAC3A7E));
      repeat (20) @(posedge clk_i);
      #2 arst_n = 1'b1;
      for (int i = 0; i < 6; i++) begin
         sz = size_type'(i % 3);
         rf = 4'($urandom);
         req();
         chk("rd_index", rdi, rf[2:0]);
         chk("rd_size", rds, sz);
         chk("rd_valid", rdv, 1);
         if (sz != SZ_LONG)
            chk("rd_hi", rdh, sz == SZ_BYTE ? !rf[3] : rf[3]);
      end
      $display("test register_direct done");
      for (int i = 0; i < 60; i++) begin
         mode = ml[i < 10 ? i % 5 : $urandom_range(4)];
         cls = mode == M_PC_REL ? C_BRANCH : C_TRANSFER;
         ln = mode == M_DISP ? len_type'(1 + $urandom_range(1)) :
              mode == M_ABS ? len_type'($urandom_range(2)) :
              mode == M_PC_REL ? len_type'($urandom_range(1)) : L_16;
         sz = size_type'($urandom_range(2));
         pd = i < 5 ? 1'b0 : i < 10 ? 1'b1 : 1'($urandom);
         rf = 4'($urandom);
         ar = i < 5 ? 32'hFFFF_FFFF : i < 10 ? 32'h0 : $urandom;
         if (mode == M_AUTO && sz != SZ_BYTE) ar[0] = 1'b0;
         pc = i < 10 ? 24'h0 : 24'($urandom);
         ext = fit(ln, i < 5 ? 32'hFFFF_FF80 : i < 10 ? 32'h8000 : $urandom);
         req();
         case (mode)
            M_REG_INDIRECT: chk("ea_ind", ea, xea());
            M_DISP: chk("ea_disp", ea, xea());
            M_AUTO: chk("ea_auto", ea, xea());
            M_ABS: chk("ea_abs", ea, xea());
            default: chk("ea_rel", ea, xea());
         endcase
         chk("ea_valid", eav, 1);
         if (mode == M_AUTO) begin
            chk("wb_en", wbe, 1);
            chk("wb_data", wbd, pd ? ar - st() : ar + st());
            chk("wb_index", wbi, rf[2:0]);
         end
      end
      $display("test address_modes done");
      cls = C_ARITH;
      mode = M_IMM;
      for (int i = 0; i < 6; i++) begin
         impl = i >= 3;
         sz = size_type'(i % 3);
         ln = i < 3 ? len_type'(i == 2 ? 3 : i) : L_8;
         ext = fit(ln, $urandom);
         req();
         chk("operand", opd, impl ? st() : ext);
         chk("operand_valid", opv, 1);
      end
      impl = 1'b0;
      trap = 1'b1;
      cls = C_SYSTEM;
      for (int i = 0; i < 4; i++) begin
         ext = i;
         req();
         chk("trap_vec", tv, VB + 16'(i * 4));
         chk("trap_valid", tvv, 1);
      end
      trap = 1'b0;
      $display("test immediate done");
      cls = C_BIT;
      bro = 1'b1;
      ln = L_16;
      for (int i = 0; i < 9; i++) begin
         mode = bm[i % 3];
         bfr = 1'($urandom);
         breg = 8'($urandom);
         bimm = 3'($urandom);
         req();
         chk("bitnum", bn, bfr ? breg[2:0] : bimm);
         chk("bitnum_valid", bnv, 1);
      end
      bro = 1'b0;
      bfr = 1'b1;
      mode = M_REG_INDIRECT;
      req();
      chk("bit_reg_misuse", err, 1);
      bfr = 1'b0;
      $display("test bit_number done");
      for (int c = 0; c < 6; c++) begin
         for (int m = 0; m < 8; m++) begin
            cls = class_type'(c);
            mode = mode_type'(m);
            ln = mode inside {M_PC_REL, M_MEM_IND} ? L_8 : L_16;
            req();
            chk("mode_err", err, !legal());
            if (!legal()) chk("ea_valid_err", eav, 0);
         end
      end
      cls = C_TRANSFER;
      mode = M_DISP;
      ln = L_8;
      req();
      chk("disp_len_err", err, 1);
      mode = M_ABS;
      ln = L_32;
      req();
      chk("abs_len_err", err, 1);
      $display("test legality done");
      // Reset in mid-run, while a done pulse is still high
      #2 arst_n = 1'b0;
      #1 chk("done_reset", done, 0);
      chk("wb_data_reset", wbd, 0);
      chk("operand_reset", opd, 0);
      repeat (2) @(posedge clk_i);
      #2 arst_n = 1'b1;
      $display("test mid_reset done");
      ptr(8'h00, 1'b0);
      ptr(8'h06, 1'b1);
      $display("test memory_indirect done");
      conclude();
   end
endmodule : effective_address_generator_tb_top
`default_nettype wire

// *** bench/ptr_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ptr_mem_model (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic req_i,
   input wire logic [31:0] data_i,
   input wire logic [7:0] lat_i,
   output logic ack_o,
   output logic [31:0] rdata_o
);
   logic [7:0] cnt;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt <= 8'h00;
         ack_o <= 1'b0;
         rdata_o <= 32'h5A5A_A5A5;
      end else if (req_i && !ack_o && cnt >= lat_i) begin
         cnt <= 8'h00;
         ack_o <= 1'b1;
         // Whole longword in one beat, top byte left to the reader
         rdata_o <= data_i;
      end else begin
         cnt <= (req_i && !ack_o) ? cnt + 8'h01 : 8'h00;
         ack_o <= 1'b0;
         // Stale data flips so a late sample cannot match by luck
         rdata_o <= ~rdata_o;
      end
   end
endmodule : ptr_mem_model
`default_nettype wire

// *** design/addr_adder.sv ***
`timescale 1ns/1ps
`default_nettype none
module addr_adder
   import eagen_pkg::*;
(
   input wire logic [DATA_W-1:0] a_i,
   input wire logic [DATA_W-1:0] b_i,
   input wire logic sub_i,
   output logic [DATA_W-1:0] sum_o
);
   // Carry out is dropped on purpose
   always_comb begin
      sum_o = a_i + (b_i ^ {DATA_W{sub_i}})
              + {{(DATA_W-1){1'b0}}, sub_i};
   end
endmodule : addr_adder
`default_nettype wire

// *** design/eagen_pkg.sv ***
package eagen_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 24;
   localparam int EA_W = 16;
   localparam int BYTE_W = 8;
   localparam int HALF_W = 16;
   localparam int RF_W = 4;
   localparam int IDX_W = 3;
   localparam int RF_HALF_BIT = 3;
   localparam int BITNUM_W = 3;
   localparam int TRAPIMM_W = 2;
   localparam int TRAP_SHIFT = 2;
   localparam logic [BYTE_W-1:0] ABS8_HIGH = 8'hFF;
   localparam logic [BYTE_W-1:0] MEMIND_HIGH = 8'h00;
   localparam logic [DATA_W-1:0] STEP_BYTE = 32'h0000_0001;
   localparam logic [DATA_W-1:0] STEP_WORD = 32'h0000_0002;
   localparam logic [DATA_W-1:0] STEP_LONG = 32'h0000_0004;
   // Plain default, nothing fixes the vector table origin
   localparam logic [EA_W-1:0] TRAP_VEC_BASE_DEF = 16'h0020;

   typedef enum logic [2:0] {
      M_REG_DIRECT, M_REG_INDIRECT, M_DISP, M_AUTO,
      M_ABS, M_IMM, M_PC_REL, M_MEM_IND
   } mode_type;
   typedef enum logic [2:0] {
      C_ARITH, C_TRANSFER, C_BIT, C_BRANCH, C_JUMP, C_SYSTEM
   } class_type;
   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_type;
   typedef enum logic [1:0] {L_8, L_16, L_24, L_32} len_type;
   typedef enum logic [1:0] {F_ZERO, F_SIGN, F_ONES} fill_type;

   function automatic logic [DATA_W-1:0] step_of(input size_type s);
      case (s)
         SZ_BYTE: return STEP_BYTE;
         SZ_WORD: return STEP_WORD;
         default: return STEP_LONG;
      endcase
   endfunction : step_of
endpackage : eagen_pkg

// *** design/effective_address_generator.sv ***
`timescale 1ns/1ps
`default_nettype none
module effective_address_generator
   import eagen_pkg::*;
#(
   parameter logic [EA_W-1:0] TRAP_VEC_BASE = TRAP_VEC_BASE_DEF
)
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic start_i,
   input wire mode_type mode_i,
   input wire class_type class_i,
   input wire logic predec_i,
   input wire size_type size_i,
   input wire len_type len_i,
   input wire logic [DATA_W-1:0] ext_i,
   input wire logic [RF_W-1:0] reg_field_i,
   input wire logic [DATA_W-1:0] address_register_i,
   input wire logic [ADDR_W-1:0] pc_i,
   input wire logic bit_from_reg_i,
   input wire logic bit_reg_op_i,
   input wire logic [BYTE_W-1:0] bit_reg_i,
   input wire logic [BITNUM_W-1:0] bit_imm_i,
   input wire logic implicit_i,
   input wire logic trap_i,
   input wire logic mem_ack_i,
   input wire logic [DATA_W-1:0] mem_rdata_i,
   output logic busy_o,
   output logic done_o,
   output logic mode_err_o,
   output logic [EA_W-1:0] ea_o,
   output logic ea_valid_o,
   output logic [DATA_W-1:0] operand_o,
   output logic operand_valid_o,
   output logic [IDX_W-1:0] rd_index_o,
   output size_type rd_size_o,
   output logic rd_hi_half_o,
   output logic rd_valid_o,
   output logic wb_en_o,
   output logic [DATA_W-1:0] wb_data_o,
   output logic [IDX_W-1:0] wb_index_o,
   output logic mem_req_o,
   output logic [EA_W-1:0] mem_addr_o,
   output logic [BITNUM_W-1:0] bitnum_o,
   output logic bitnum_valid_o,
   output logic [EA_W-1:0] trap_vec_o,
   output logic trap_valid_o
);
   localparam int PC_PAD = DATA_W - ADDR_W;

   typedef enum logic {ST_IDLE, ST_FETCH} st_type;

   typedef struct packed {
      st_type st;
      logic busy;
      logic done;
      logic err;
      logic [EA_W-1:0] ea;
      logic ea_valid;
      logic [DATA_W-1:0] operand;
      logic operand_valid;
      logic [IDX_W-1:0] rd_index;
      size_type rd_size;
      logic rd_hi_half;
      logic rd_valid;
      logic wb_en;
      logic [DATA_W-1:0] wb_data;
      logic [IDX_W-1:0] wb_index;
      logic mem_req;
      logic [EA_W-1:0] mem_addr;
      logic [BITNUM_W-1:0] bitnum;
      logic bitnum_valid;
      logic [EA_W-1:0] trap_vec;
      logic trap_valid;
   } state_type;

   state_type r;
   state_type next_r;

   logic accepted;
   logic mode_ok;
   logic len_ok;
   logic legal;
   fill_type fill;
   logic [DATA_W-1:0] ext_val;
   logic [DATA_W-1:0] add_a;
   logic [DATA_W-1:0] add_b;
   logic add_sub;
   logic [DATA_W-1:0] sum;

   // Full 24-bit address first, then only the low 16 bits go out
   function automatic logic [EA_W-1:0] to_ea(
      input logic [DATA_W-1:0] x);
      logic [ADDR_W-1:0] a24;
      a24 = x[ADDR_W-1:0];
      return a24[EA_W-1:0];
   endfunction : to_ea

   assign accepted = start_i && (r.st == ST_IDLE);

   always_comb begin
      case (class_i)
         C_ARITH: mode_ok = (mode_i == M_REG_DIRECT) ||
                            (mode_i == M_IMM);
         C_TRANSFER: mode_ok = (mode_i != M_PC_REL) &&
                               (mode_i != M_MEM_IND);
         C_BIT: mode_ok = (mode_i inside {M_REG_DIRECT,
                             M_REG_INDIRECT, M_ABS}) &&
                          (!bit_from_reg_i ||
                           bit_reg_op_i);
         C_BRANCH: mode_ok = (mode_i == M_PC_REL);
         C_JUMP: mode_ok = mode_i inside {M_REG_INDIRECT,
                              M_ABS, M_MEM_IND};
         C_SYSTEM: mode_ok = (mode_i == M_IMM) ||
                             (mode_i == M_REG_DIRECT);
         default: mode_ok = 1'b0;
      endcase
      case (mode_i)
         M_DISP: len_ok = len_i inside {L_16, L_24};
         M_ABS: len_ok = len_i inside {L_8, L_16, L_24};
         M_IMM: len_ok = implicit_i || trap_i ||
                         (len_i inside {L_8, L_16, L_32});
         M_PC_REL: len_ok = len_i inside {L_8, L_16};
         M_MEM_IND: len_ok = (len_i == L_8);
         default: len_ok = 1'b1;
      endcase
      legal = mode_ok && len_ok;
   end

   always_comb begin
      case (mode_i)
         M_ABS: fill = (len_i == L_8) ? F_ONES
                                      : F_SIGN;
         M_DISP: fill = F_SIGN;
         M_PC_REL: fill = F_SIGN;
         default: fill = F_ZERO;
      endcase
   end

   ext_fill u_ext (
      .raw_i(ext_i),
      .len_i(len_i),
      .fill_i(fill),
      .ext_o(ext_val)
   );

   always_comb begin
      add_a = address_register_i;
      add_b = ext_val;
      add_sub = 1'b0;
      if (mode_i == M_AUTO) begin
         add_b = step_of(size_i);
         add_sub = predec_i;
      end else if (mode_i == M_PC_REL) begin
         // PC already points past the branch
         add_a = {{PC_PAD{1'b0}}, pc_i};
      end
   end

   addr_adder u_add (
      .a_i(add_a),
      .b_i(add_b),
      .sub_i(add_sub),
      .sum_o(sum)
   );

   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.err = 1'b0;
      next_r.ea_valid = 1'b0;
      next_r.operand_valid = 1'b0;
      next_r.rd_valid = 1'b0;
      next_r.wb_en = 1'b0;
      next_r.bitnum_valid = 1'b0;
      next_r.trap_valid = 1'b0;
      case (r.st)
         ST_IDLE: begin
            if (start_i && !legal) begin
               next_r.err = 1'b1;
               next_r.done = 1'b1;
            end else if (start_i) begin
               next_r.done = 1'b1;
               case (mode_i)
                  M_REG_DIRECT: begin
                     next_r.rd_valid = 1'b1;
                     next_r.rd_index = reg_field_i[IDX_W-1:0];
                     next_r.rd_size = size_i;
                     // Byte: high half when bit clear; word: E half
                     if (size_i == SZ_BYTE) begin
                        next_r.rd_hi_half = !reg_field_i[RF_HALF_BIT];
                     end else if (size_i == SZ_WORD) begin
                        next_r.rd_hi_half = reg_field_i[RF_HALF_BIT];
                     end else begin
                        next_r.rd_hi_half = 1'b0;
                     end
                  end
                  M_REG_INDIRECT: begin
                     next_r.ea = to_ea(address_register_i);
                     next_r.ea_valid = 1'b1;
                  end
                  M_DISP, M_PC_REL: begin
                     next_r.ea = to_ea(sum);
                     next_r.ea_valid = 1'b1;
                  end
                  M_AUTO: begin
                     next_r.ea = predec_i ? to_ea(sum)
                        : to_ea(address_register_i);
                     next_r.ea_valid = 1'b1;
                     next_r.wb_en = 1'b1;
                     next_r.wb_data = sum;
                     next_r.wb_index = reg_field_i[IDX_W-1:0];
                  end
                  M_ABS: begin
                     next_r.ea = to_ea(ext_val);
                     next_r.ea_valid = 1'b1;
                  end
                  M_IMM: begin
                     next_r.operand_valid = 1'b1;
                     if (trap_i) begin
                        next_r.trap_valid = 1'b1;
                        next_r.trap_vec = TRAP_VEC_BASE +
                           (EA_W'(ext_i[TRAPIMM_W-1:0]) << TRAP_SHIFT);
                        next_r.operand = DATA_W'(ext_i[TRAPIMM_W-1:0]);
                     end else if (implicit_i) begin
                        next_r.operand = step_of(size_i);
                     end else begin
                        next_r.operand = ext_val;
                     end
                  end
                  default: begin
                     // Pointer lies in the low page
                     next_r.done = 1'b0;
                     next_r.st = ST_FETCH;
                     next_r.busy = 1'b1;
                     next_r.mem_req = 1'b1;
                     next_r.mem_addr = to_ea(ext_val);
                  end
               endcase
               if (class_i == C_BIT) begin
                  next_r.bitnum_valid = 1'b1;
                  next_r.bitnum = bit_from_reg_i
                     ? bit_reg_i[BITNUM_W-1:0] : bit_imm_i;
               end
            end
         end
         default: begin
            if (mem_ack_i) begin
               // Top two pointer bytes dropped
               next_r.ea = to_ea({{PC_PAD{1'b0}},
                                  mem_rdata_i[ADDR_W-1:0]});
               next_r.ea_valid = 1'b1;
               next_r.done = 1'b1;
               next_r.mem_req = 1'b0;
               next_r.busy = 1'b0;
               next_r.st = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign busy_o = r.busy;
   assign done_o = r.done;
   assign mode_err_o = r.err;
   assign ea_o = r.ea;
   assign ea_valid_o = r.ea_valid;
   assign operand_o = r.operand;
   assign operand_valid_o = r.operand_valid;
   assign rd_index_o = r.rd_index;
   assign rd_size_o = r.rd_size;
   assign rd_hi_half_o = r.rd_hi_half;
   assign rd_valid_o = r.rd_valid;
   assign wb_en_o = r.wb_en;
   assign wb_data_o = r.wb_data;
   assign wb_index_o = r.wb_index;
   assign mem_req_o = r.mem_req;
   assign mem_addr_o = r.mem_addr;
   assign bitnum_o = r.bitnum;
   assign bitnum_valid_o = r.bitnum_valid;
   assign trap_vec_o = r.trap_vec;
   assign trap_valid_o = r.trap_valid;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   sequence s_ind_issue;
      accepted && legal && (mode_i == M_MEM_IND);
   endsequence
   sequence s_ptr_back;
      mem_req_o && mem_ack_i;
   endsequence

   a_memind_issue: assert property (
      s_ind_issue |=> mem_req_o && busy_o && !done_o &&
         mem_addr_o == {MEMIND_HIGH, $past(ext_i[BYTE_W-1:0])})
      else $error("pointer fetch address wrong");
   a_ptr_result: assert property (
      s_ptr_back |=> ea_valid_o && done_o && !mem_req_o &&
         ea_o == $past(mem_rdata_i[EA_W-1:0]))
      else $error("indirect branch address wrong");
   a_req_holds: assert property (
      mem_req_o && !mem_ack_i |=> mem_req_o && !ea_valid_o)
      else $error("pointer request dropped early");
   a_abs8_fill: assert property (
      accepted && legal && mode_i == M_ABS && len_i == L_8
      |=> ea_valid_o &&
         ea_o == {ABS8_HIGH, $past(ext_i[BYTE_W-1:0])})
      else $error("short absolute not in top page");
   a_abs16_pass: assert property (
      accepted && legal && mode_i == M_ABS && len_i != L_8
      |=> ea_o == $past(ext_i[EA_W-1:0]))
      else $error("absolute address altered");
   a_postinc_step: assert property (
      accepted && legal && mode_i == M_AUTO && !predec_i
      |=> wb_en_o &&
         ea_o == $past(address_register_i[EA_W-1:0]) &&
         wb_data_o == $past(address_register_i) +
                      step_of($past(size_i)))
      else $error("post-increment wrong");
   a_predec_step: assert property (
      accepted && legal && mode_i == M_AUTO && predec_i
      |=> wb_en_o && ea_o == wb_data_o[EA_W-1:0] &&
         wb_data_o == $past(address_register_i) -
                      step_of($past(size_i)))
      else $error("pre-decrement wrong");
   a_disp_sum: assert property (
      accepted && legal && mode_i == M_DISP && len_i == L_16
      |=> ea_o == EA_W'($past(address_register_i) +
                        $past(ext_i[HALF_W-1:0])))
      else $error("displacement sum wrong");
   a_pcrel_short: assert property (
      accepted && legal && mode_i == M_PC_REL && len_i == L_8
      |=> ea_o == EA_W'($past(pc_i) + {{(ADDR_W-BYTE_W)
            {$past(ext_i[BYTE_W-1])}}, $past(ext_i[BYTE_W-1:0])}))
      else $error("relative branch target wrong");
   a_arith_modes: assert property (
      accepted && class_i == C_ARITH &&
      !(mode_i inside {M_REG_DIRECT, M_IMM})
      |=> mode_err_o && done_o && !ea_valid_o && !wb_en_o)
      else $error("illegal arithmetic mode passed");
   a_xfer_modes: assert property (
      accepted && class_i == C_TRANSFER &&
      mode_i inside {M_PC_REL, M_MEM_IND}
      |=> mode_err_o && !mem_req_o)
      else $error("illegal transfer mode passed");
   a_bit_source: assert property (
      accepted && legal && class_i == C_BIT && bit_from_reg_i
      |=> bitnum_valid_o &&
         bitnum_o == $past(bit_reg_i[BITNUM_W-1:0]))
      else $error("bit number not from register");
   a_imm_value: assert property (
      accepted && legal && mode_i == M_IMM && !trap_i &&
      !implicit_i && len_i == L_8
      |=> operand_valid_o && operand_o ==
         {{(DATA_W-BYTE_W){1'b0}}, $past(ext_i[BYTE_W-1:0])})
      else $error("immediate operand wrong");
endmodule : effective_address_generator
`default_nettype wire

// *** design/ext_fill.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_fill
   import eagen_pkg::*;
(
   input wire logic [DATA_W-1:0] raw_i,
   input wire len_type len_i,
   input wire fill_type fill_i,
   output logic [DATA_W-1:0] ext_o
);
   localparam int PAD8 = DATA_W - BYTE_W;
   localparam int PAD16 = DATA_W - HALF_W;
   localparam int PAD24 = DATA_W - ADDR_W;

   function automatic logic fill_bit(input logic msb);
      case (fill_i)
         F_ONES: return 1'b1;
         F_SIGN: return msb;
         default: return 1'b0;
      endcase
   endfunction : fill_bit

   always_comb begin
      case (len_i)
         L_8: ext_o = {{PAD8{fill_bit(raw_i[BYTE_W-1])}},
                       raw_i[BYTE_W-1:0]};
         L_16: ext_o = {{PAD16{fill_bit(raw_i[HALF_W-1])}},
                        raw_i[HALF_W-1:0]};
         // Top byte always zero for 24-bit fields
         L_24: ext_o = {{PAD24{1'b0}}, raw_i[ADDR_W-1:0]};
         default: ext_o = raw_i;
      endcase
   end
endmodule : ext_fill
`default_nettype wire
